/* File: burst_master_pkg.sv */
// Constants shared by the burst master that drives the bursting slave port.
// Assumes one application clock domain for master and slave port.
package burst_master_pkg;
  localparam int MAX_BURST_BYTES = 512;
  localparam int DATA_W_NARROW   = 64;
  localparam int DATA_W_WIDE     = 128;
  localparam int COUNT_W_NARROW  = 6;
  localparam int COUNT_W_WIDE    = 5;
  localparam int FIFO_DEPTH      = 8;
  localparam int ADDR_W          = 32;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WAIT_DATA,
    ST_WRITE
  } burst_state_t;
endpackage : burst_master_pkg

/* File: beat_stream_if.sv */
// Valid/ready word stream between the command logic and the write FIFO.
// Assumes both ends share the clock of the master.
`timescale 1ns/1ps
interface beat_stream_if #(
  parameter int WIDTH = 64
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : beat_stream_if

/* File: word_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; clock enable low freezes all state.
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  beat_stream_if.sink   fill,
  beat_stream_if.source drain
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign fill.ready  = (count != (PW+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = mem[rd_ptr];
  assign push        = i_ce && fill.valid && fill.ready;
  assign pop         = i_ce && drain.valid && drain.ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  chk_fifo_no_overflow:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      count <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule : word_fifo

/* File: burst_master.sv */
// Bursting master that drives the slave port of the PCIe request bridge.
// Assumes the bridge shares i_clk; translation and packets are its job.
// Functional notes
// - Burst carries at most 512 bytes.
// - Port select high with every request.
// - Read asserts request, address and count.
// - Write request held gapless over burst.
// - Whole write burst buffered before issue.
// - Data buses 64 or 128 bits.
// - Count in beats, 6 or 5 bits.
// - Middle beats use all-ones lane enables.
// - Lane enable one bit per byte.
// - Hold request and data during hold-off.
// - Reads no larger than 512 bytes.
`timescale 1ns/1ps
module burst_master
#(
  parameter int DATA_W  = burst_master_pkg::DATA_W_NARROW,
  parameter int ADDR_W  = burst_master_pkg::ADDR_W,
  parameter int DEPTH   = burst_master_pkg::FIFO_DEPTH,
  parameter int COUNT_W = (DATA_W == burst_master_pkg::DATA_W_NARROW)
                          ? burst_master_pkg::COUNT_W_NARROW
                          : burst_master_pkg::COUNT_W_WIDE,
  parameter int BE_W    = DATA_W / 8
) (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_ce,
  // User command side
  input  wire logic               i_cmd_valid,
  input  wire logic               i_cmd_write,
  input  wire logic [ADDR_W-1:0]  i_cmd_address,
  input  wire logic [COUNT_W-1:0] i_cmd_beats,
  input  wire logic [BE_W-1:0]    i_cmd_first_lanes,
  input  wire logic [BE_W-1:0]    i_cmd_last_lanes,
  output logic                    o_cmd_ready,
  output logic                    o_cmd_error,
  // User write data side
  input  wire logic               i_wr_valid,
  input  wire logic [DATA_W-1:0]  i_wr_data,
  output logic                    o_wr_ready,
  // User read data side
  output logic                    o_rd_valid,
  output logic [DATA_W-1:0]       o_rd_data,
  output logic                    o_rd_last,
  output logic                    o_busy,
  // Bridge slave port
  output logic                    o_port_select_in,
  output logic                    o_read_request_in,
  output logic                    o_write_request_in,
  output logic [DATA_W-1:0]       o_write_word_in,
  output logic [COUNT_W-1:0]      o_beat_count_in,
  output logic [ADDR_W-1:0]       o_request_address_in,
  output logic [BE_W-1:0]         o_lane_enable_in,
  input  wire logic               i_read_word_valid_out,
  input  wire logic [DATA_W-1:0]  i_read_word_out,
  input  wire logic               i_hold_off_out
);
  import burst_master_pkg::*;

  localparam int BEAT_BYTES = DATA_W / 8;
  localparam logic [BE_W-1:0] LANES_ALL = '1;

  burst_state_t     state;
  burst_state_t     next_state;
  logic [COUNT_W-1:0] beats_left;
  logic [COUNT_W-1:0] beats_total;
  logic [BE_W-1:0]    last_lanes;
  logic [COUNT_W:0]   buffered;
  logic               cmd_ok;
  logic               take_cmd;
  logic               beat_go;

  beat_stream_if #(.WIDTH(DATA_W)) wr_in  ();
  beat_stream_if #(.WIDTH(DATA_W)) wr_out ();

  // Count zero means the maximum, the same as a full bus wrap
  function automatic logic [COUNT_W:0] beats_of(input logic [COUNT_W-1:0] c);
    beats_of = (c == '0) ? {1'b1, {COUNT_W{1'b0}}} : {1'b0, c};
  endfunction : beats_of

  // Bursts over the byte limit are refused rather than split
  assign cmd_ok = (int'(beats_of(i_cmd_beats)) * BEAT_BYTES
                   <= MAX_BURST_BYTES);
  assign o_cmd_ready = (state == ST_IDLE) && i_ce
                       && (!i_cmd_write
                           || buffered >= beats_of(i_cmd_beats));
  assign take_cmd = i_cmd_valid && o_cmd_ready;
  assign o_busy   = (state != ST_IDLE);

  // Write data is staged so the burst never has to pause
  assign wr_in.valid = i_wr_valid;
  assign wr_in.data  = i_wr_data;
  assign o_wr_ready  = wr_in.ready;

  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .fill   (wr_in),
    .drain  (wr_out)
  );

  // A beat moves only when the bridge is not holding off
  assign beat_go = (state == ST_WRITE) && !i_hold_off_out;
  assign wr_out.ready = beat_go && i_ce;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      buffered <= '0;
    end else if (i_ce) begin
      if ((wr_in.valid && wr_in.ready)
          && !(wr_out.valid && wr_out.ready)) begin
        buffered <= buffered + 1'b1;
      end else if (!(wr_in.valid && wr_in.ready) && wr_out.ready
                   && wr_out.valid) begin
        buffered <= buffered - 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take_cmd && cmd_ok) begin
          next_state = i_cmd_write ? ST_WRITE : ST_READ;
        end
      end
      ST_READ: begin
        if (!i_hold_off_out) begin
          next_state = ST_WAIT_DATA;
        end
      end
      ST_WAIT_DATA: begin
        if (i_read_word_valid_out && beats_left == COUNT_W'(1)) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (beat_go && beats_left == COUNT_W'(1)) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // Request fields; held stable through hold-off
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_request_address_in <= '0;
      o_beat_count_in      <= '0;
      beats_total          <= '0;
      last_lanes           <= '0;
      o_cmd_error          <= 1'b0;
    end else if (i_ce) begin
      o_cmd_error <= take_cmd && !cmd_ok;
      if (take_cmd && cmd_ok) begin
        o_request_address_in <= i_cmd_address;
        o_beat_count_in      <= i_cmd_beats;
        beats_total          <= i_cmd_beats;
        last_lanes           <= i_cmd_last_lanes;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      beats_left <= '0;
    end else if (i_ce) begin
      if (take_cmd && cmd_ok) begin
        beats_left <= i_cmd_beats;
      end else if (beat_go
                   || (state == ST_WAIT_DATA && i_read_word_valid_out)) begin
        beats_left <= beats_left - 1'b1;
      end
    end
  end

  // Lane enables: partial only on first and last beats
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_lane_enable_in <= '0;
    end else if (i_ce) begin
      if (take_cmd && cmd_ok) begin
        o_lane_enable_in <= !i_cmd_write ? LANES_ALL
                          : (i_cmd_beats == COUNT_W'(1)) ? i_cmd_first_lanes
                          & i_cmd_last_lanes : i_cmd_first_lanes;
      end else if (beat_go) begin
        o_lane_enable_in <= (beats_left == COUNT_W'(2)) ? last_lanes
                          : LANES_ALL;
      end
    end
  end

  assign o_port_select_in   = (state == ST_READ)
                              || (state == ST_WRITE);
  assign o_read_request_in  = (state == ST_READ);
  assign o_write_request_in = (state == ST_WRITE);
  assign o_write_word_in    = wr_out.data;

  // Returned words are registered; count reaching one ends the read
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
      o_rd_last  <= 1'b0;
    end else if (i_ce) begin
      o_rd_valid <= (state == ST_WAIT_DATA)
                    && i_read_word_valid_out;
      o_rd_last  <= (state == ST_WAIT_DATA) && i_read_word_valid_out
                    && beats_left == COUNT_W'(1);
      if (i_read_word_valid_out) begin
        o_rd_data <= i_read_word_out;
      end
    end
  end

  chk_write_gapless:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_write_request_in && i_ce)
      |-> wr_out.valid)
    else $error("write beat missing data");

  chk_hold_stable:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_read_request_in && i_hold_off_out && i_ce)
      |=> o_read_request_in && $stable(o_request_address_in))
    else $error("read request changed during hold-off");

  chk_burst_size:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_port_select_in |-> int'(beats_of(o_beat_count_in)) * BEAT_BYTES
                           <= MAX_BURST_BYTES)
    else $error("burst above byte limit");

  chk_select_req:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_read_request_in || o_write_request_in) |-> o_port_select_in)
    else $error("request without port select");

  chk_mid_lanes:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_write_request_in && beats_left != beats_total
       && beats_left > COUNT_W'(1)) |-> o_lane_enable_in == LANES_ALL)
    else $error("middle beat lanes not all ones");

  chk_read_valid:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (state == ST_WAIT_DATA && i_read_word_valid_out && i_ce)
      |=> o_rd_valid && o_rd_data == $past(i_read_word_out))
    else $error("read beat not forwarded");

  chk_read_end:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_rd_last && i_ce) |-> state == ST_IDLE)
    else $error("read finished with beats left");

  chk_write_buffered:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      ($rose(o_write_request_in)) |-> buffered >= beats_of(beats_left))
    else $error("write issued before fully buffered");

  chk_write_hold:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_write_request_in && i_hold_off_out && i_ce)
      |=> o_write_request_in && $stable(o_write_word_in)
          && $stable(o_lane_enable_in))
    else $error("write beat changed during hold-off");

  chk_write_last:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (beat_go && i_ce && beats_left == COUNT_W'(1))
      |=> !o_write_request_in)
    else $error("write request beyond last beat");

  chk_error_quiet:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_cmd_error |-> !o_port_select_in)
    else $error("refused burst reached the port");

  chk_read_lanes:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_read_request_in |-> o_lane_enable_in == LANES_ALL)
    else $error("read request lanes not all ones");

  chk_count_held:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_port_select_in && i_ce)
      |=> !o_port_select_in || $stable(o_beat_count_in))
    else $error("beat count changed during request");
endmodule : burst_master

/* File: bridge_port_model.sv */
// Behavioural model of the bridge slave port driven by the burst master.
// Assumes the master's clock; 64-bit data path, memory of 256 words.
`timescale 1ns/1ps
module bridge_port_model #(
  parameter int LAT = 3
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_stall,
  input  wire logic        i_sel,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [63:0] i_wdata,
  input  wire logic [5:0]  i_count,
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_lanes,
  output logic             o_rvalid,
  output logic [63:0]      o_rdata,
  output logic             o_hold
);
  logic [63:0] mem [0:255];
  logic [6:0]  left;
  logic [7:0]  ptr;
  logic [7:0]  wbeat;
  logic [7:0]  widx;
  logic [3:0]  delay;
  logic [1:0]  tick;
  logic [63:0] mask;

  initial begin
    for (int k = 0; k < 256; k++) begin
      mem[k] = 64'hA5A5A5A500000000 | 64'(k);
    end
  end

  assign widx = i_addr[10:3] + wbeat;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      mask[8*b +: 8] = {8{i_lanes[b]}};
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      left     <= 7'h00;
      ptr      <= 8'h00;
      wbeat    <= 8'h00;
      delay    <= 4'h0;
      tick     <= 2'h0;
      o_hold   <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata  <= 64'h0;
    end else begin
      tick     <= tick + 2'h1;
      o_hold   <= i_stall & tick[0];
      o_rvalid <= 1'b0;
      // Idle bus toggles so a stale beat never looks valid
      o_rdata  <= ~o_rdata;
      if (i_sel && i_rd && !o_hold && left == 7'h00) begin
        left  <= (i_count == 6'h00) ? 7'h40 : {1'b0, i_count};
        ptr   <= i_addr[10:3];
        delay <= 4'(LAT);
      end else if (left != 7'h00) begin
        if (delay != 4'h0) begin
          delay <= delay - 4'h1;
        end else if (!(i_stall && tick[1])) begin
          o_rvalid <= 1'b1;
          o_rdata  <= mem[ptr];
          ptr      <= ptr + 8'h01;
          left     <= left - 7'h01;
        end
      end
      if (i_sel && i_wr) begin
        if (!o_hold) begin
          mem[widx] <= (mem[widx] & ~mask) | (i_wdata & mask);
          wbeat     <= wbeat + 8'h01;
        end
      end else begin
        wbeat <= 8'h00;
      end
    end
  end
endmodule : bridge_port_model

/* File: burst_slave_to_pcie_request_bridge_tb_top.sv */
// Testbench of the burst master against the bridge port model.
// Assumes a 100 ns clock; model latency and stall pattern fixed.
`timescale 1ns/1ps
module burst_slave_to_pcie_request_bridge_tb_top;
  import burst_master_pkg::*;
  logic        clk, rstn, stall, cmd_valid, cmd_write, cmd_ready, cmd_error;
  logic        wr_valid, wr_ready, rd_valid, rd_last, busy, hold, p_hold;
  logic        sel, rreq, wreq, rvo, p_wreq, p_rreq, ce;
  logic [31:0] cmd_addr, addr, p_addr;
  logic [5:0]  cmd_beats, cnt;
  logic [7:0]  first_l, last_l, lanes;
  logic [63:0] wr_data, rd_data, wword, rwo, p_word;
  logic [63:0] rd_q[$];
  logic        last_q[$];
  logic [7:0]  lane_q[$];
  int          n_fail, n_checks, wr_runs;

  burst_master #(.DATA_W(DATA_W_NARROW)) i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_address(cmd_addr),
    .i_cmd_beats(cmd_beats), .i_cmd_first_lanes(first_l),
    .i_cmd_last_lanes(last_l), .o_cmd_ready(cmd_ready),
    .o_cmd_error(cmd_error), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
    .o_wr_ready(wr_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .o_rd_last(rd_last), .o_busy(busy), .o_port_select_in(sel),
    .o_read_request_in(rreq), .o_write_request_in(wreq),
    .o_write_word_in(wword), .o_beat_count_in(cnt),
    .o_request_address_in(addr), .o_lane_enable_in(lanes),
    .i_read_word_valid_out(rvo), .i_read_word_out(rwo),
    .i_hold_off_out(hold));
  bridge_port_model i_model (
    .i_clk(clk), .i_rstn(rstn), .i_stall(stall), .i_sel(sel),
    .i_rd(rreq), .i_wr(wreq), .i_wdata(wword), .i_count(cnt),
    .i_addr(addr), .i_lanes(lanes), .o_rvalid(rvo), .o_rdata(rwo),
    .o_hold(hold));

  always #50 clk = ~clk;

  function automatic logic [63:0] init_w(input int k);
    return 64'hA5A5A5A500000000 | 64'(k);
  endfunction : init_w
  function automatic logic [63:0] word(input int i);
    return 64'h0123456789AB0000 | 64'(i);
  endfunction : word
  // Partial lanes keep the old bytes of the first and last word
  function automatic logic [63:0] exp_word(input int i);
    if (i == 0) return (init_w(32) & 64'hFFFFFFFF00000000)
                       | (word(0) & 64'h00000000FFFFFFFF);
    if (i == 7) return (word(7) & 64'hFFFFFFFF00000000)
                       | (init_w(39) & 64'h00000000FFFFFFFF);
    return word(i);
  endfunction : exp_word

  task automatic check(input string what, input logic [63:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step;
    @(posedge clk);
    #10;
  endtask : step
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic cmd(input logic w, input logic [31:0] a,
                     input logic [5:0] n);
    cmd_write = w;
    cmd_addr  = a;
    cmd_beats = n;
    cmd_valid = 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #10 cmd_valid = 1'b0;
    check("cmd error", cmd_error, 1'b0);
    check("req addr", addr, a);
    check("req count", cnt, n);
    check("req kind", {wreq, rreq}, {w, !w});
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) step();
    check("cmd done", busy, 1'b0);
    step();
    rd_q.delete();
    last_q.delete();
  endtask : cmd

  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      rd_q.push_back(rd_data);
      last_q.push_back(rd_last);
    end
    if ((wreq | rreq) === 1'b1) check("select", sel, 1'b1);
    if (wreq === 1'b1 && hold === 1'b0) lane_q.push_back(lanes);
    if (wreq === 1'b1 && p_wreq !== 1'b1) wr_runs++;
    if (p_hold === 1'b1 && (p_wreq | p_rreq) === 1'b1) begin
      check("held addr", addr, p_addr);
      if (p_wreq === 1'b1) check("held word", wword, p_word);
    end
    p_hold <= hold;
    p_wreq <= wreq;
    p_rreq <= rreq;
    p_addr <= addr;
    p_word <= wword;
  end

  task automatic test_write;
    logic [7:0] exp_l;
    wr_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr_data = word(i);
      do @(posedge clk); while (wr_ready !== 1'b1);
      #10;
    end
    wr_valid = 1'b0;
    check("fifo full", wr_ready, 1'b0);
    stall = 1'b1;
    cmd(1'b1, 32'h100, 6'h08);
    stall = 1'b0;
    check("write runs", wr_runs, 1);
    check("lane beats", lane_q.size(), 8);
    for (int i = 0; i < 8; i++) begin
      exp_l = (i == 0) ? 8'h0F : (i == 7) ? 8'hF0 : 8'hFF;
      check("lanes", lane_q[i], exp_l);
    end
    check("fifo empty", wr_ready, 1'b1);
    $display("test_write done");
  endtask : test_write

  task automatic read_back(input logic [31:0] a, input logic [5:0] n,
                           input int beats, input int base, input bit wr);
    int got;
    logic [63:0] q[$];
    logic        l[$];
    logic [63:0] exp_w;
    fork
      cmd(1'b0, a, n);
      begin
        wait (busy === 1'b1);
        wait (busy === 1'b0);
        @(posedge clk);
        #1 q = rd_q;
        l = last_q;
      end
    join
    got = q.size();
    check("read beats", got, beats);
    for (int i = 0; i < beats && i < got; i++) begin
      exp_w = wr ? exp_word(i) : init_w(base + i);
      check("read word", q[i], exp_w);
      check("read last", l[i], i == beats - 1);
    end
  endtask : read_back

  task automatic test_read;
    stall = 1'b1;
    read_back(32'h100, 6'h08, 8, 32, 1'b1);
    stall = 1'b0;
    $display("test_read done");
  endtask : test_read

  task automatic test_max_read;
    read_back(32'h400, 6'h00, 64, 128, 1'b0);
    $display("test_max_read done");
  endtask : test_max_read

  // Words offered while the enable is low must not count as buffered
  task automatic test_ce;
    ce        = 1'b0;
    wr_valid  = 1'b1;
    wr_data   = word(9);
    repeat (3) step();
    check("frozen ready", cmd_ready, 1'b0);
    wr_valid  = 1'b0;
    ce        = 1'b1;
    cmd_write = 1'b1;
    cmd_beats = 6'h01;
    step();
    check("nothing buffered", cmd_ready, 1'b0);
    wr_valid = 1'b1;
    step();
    wr_valid = 1'b0;
    first_l  = 8'h3C;
    last_l   = 8'hFF;
    cmd(1'b1, 32'h200, 6'h01);
    check("single beats", lane_q.size(), 9);
    check("single lanes", lane_q[8], 8'h3C);
    $display("test_ce done");
  endtask : test_ce

  initial begin
    {clk, rstn, stall, cmd_valid, cmd_write, wr_valid} = 6'h00;
    {cmd_addr, cmd_beats, wr_data} = '0;
    first_l = 8'h0F;
    last_l  = 8'hF0;
    ce      = 1'b1;
    repeat (10) @(posedge clk);
    #10 rstn = 1'b1;
    check("reset request", wreq | rreq, 1'b0);
    test_write();
    test_read();
    test_max_read();
    test_ce();
    give_verdict();
  end

  initial begin
    #1000000;
    n_fail++;
    give_verdict();
  end
endmodule : burst_slave_to_pcie_request_bridge_tb_top
